// file: include/nbcer_pkg.sv
package nbcer_pkg;
  // Width of the held word, one stored bit per data input
  localparam int NBCER_WIDTH = 9;
  // Value the stored word takes at reset and on clear
  localparam logic [NBCER_WIDTH-1:0] NBCER_ZERO_WORD = 9'h000;
  // Output enable pattern that floats every output
  localparam logic [NBCER_WIDTH-1:0] NBCER_FLOAT_ALL = 9'h1ff;
  // Flip-flops between a pin and the first logic that reads it
  localparam int NBCER_SYNC_STAGES = 2;
  // Sampled control pins, in the order they are packed for the synchroniser
  localparam int NBCER_CTL_LOAD_CLOCK = 0;
  localparam int NBCER_CTL_LOAD_GATE_N = 1;
  localparam int NBCER_CTL_ZERO_N = 2;
  localparam int NBCER_CTL_OUT_EN_N = 3;
  localparam int NBCER_CTL_COUNT = 4;
  // Idle pin levels loaded at reset: gate off, clear off, outputs floating
  localparam logic [NBCER_CTL_COUNT-1:0] NBCER_CTL_IDLE = 4'he;
endpackage

// file: core/nbcer_sync.sv
module nbcer_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  import nbcer_pkg::*;

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration check
  if (WIDTH < 1) begin : g_bad_width
    $error("nbcer_sync needs a width of at least one");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two stages; the first is read by the second only, to let metastability
  // settle before any logic looks at the pin
  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= RESET_VALUE;
      sync_reg <= RESET_VALUE;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;
endmodule

// file: core/nbcer_core.sv
// Operation
// - Hold nine stored bits, nine three-state outputs.
// - Gate low: capture data on load clock rise.
// - Gate high: stored bits keep their values.
// - Clear low forces bits low, overrides loading.
// - Output enable high floats all nine outputs.
// - Output enable low drives true stored values.
module nbcer_core #(
  parameter int WIDTH = nbcer_pkg::NBCER_WIDTH
) (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic [WIDTH-1:0] DATA_IN,
  input wire logic LOAD_CLOCK,
  input wire logic LOAD_GATE_N,
  input wire logic ZERO_STORED_N,
  input wire logic OUT_EN_N,
  output logic [WIDTH-1:0] BUS_OUT,
  output logic [WIDTH-1:0] BUS_OUT_OE_N
);
  import nbcer_pkg::*;

  localparam int SYNC_W = WIDTH + NBCER_CTL_COUNT;

  logic [SYNC_W-1:0] pins_raw;
  logic [SYNC_W-1:0] pins_s;
  logic [WIDTH-1:0] data_s;
  logic load_clock_s;
  logic load_gate_n_s;
  logic zero_stored_n_s;
  logic out_en_n_s;
  logic clock_prev_reg;
  logic clock_prev_next;
  logic clock_rise;
  logic [WIDTH-1:0] stored_bit_reg;
  logic [WIDTH-1:0] stored_bit_next;
  logic [WIDTH-1:0] oe_n_reg;
  logic [WIDTH-1:0] oe_n_next;

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration check: the word must fit the reset constants
  if (WIDTH < 1 || WIDTH > NBCER_WIDTH) begin : g_bad_width
    $error("nbcer_core width must lie between one and the held word width");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; data shares the stages of the load clock so a word
  // and the edge that captures it stay aligned. Limitation: the load clock
  // must stay high and low for at least two system cycles each.
  assign pins_raw = {DATA_IN, OUT_EN_N, ZERO_STORED_N, LOAD_GATE_N,
                     LOAD_CLOCK};

  nbcer_sync #(
    .WIDTH(SYNC_W),
    .RESET_VALUE({NBCER_ZERO_WORD[WIDTH-1:0], NBCER_CTL_IDLE})
  ) u_sync (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .async_in(pins_raw),
    .sync_out(pins_s)
  );

  assign load_clock_s = pins_s[NBCER_CTL_LOAD_CLOCK];
  assign load_gate_n_s = pins_s[NBCER_CTL_LOAD_GATE_N];
  assign zero_stored_n_s = pins_s[NBCER_CTL_ZERO_N];
  assign out_en_n_s = pins_s[NBCER_CTL_OUT_EN_N];
  assign data_s = pins_s[SYNC_W-1:NBCER_CTL_COUNT];

  ////////////////////////////////////////////////////////////////////////////
  // Load clock edge detect, taken from the settled stage only
  always_comb begin
    clock_prev_next = load_clock_s;
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      clock_prev_reg <= 1'b0;
    end else begin
      clock_prev_reg <= clock_prev_next;
    end
  end

  assign clock_rise = load_clock_s & ~clock_prev_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Stored word: clear first, then gated load, else hold. The output
  // enable is deliberately absent here so floating never disturbs it.
  always_comb begin
    stored_bit_next = stored_bit_reg;
    if (!zero_stored_n_s) begin
      stored_bit_next = NBCER_ZERO_WORD[WIDTH-1:0];
    end else if (clock_rise && !load_gate_n_s) begin
      stored_bit_next = data_s;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      stored_bit_reg <= NBCER_ZERO_WORD[WIDTH-1:0];
    end else begin
      stored_bit_reg <= stored_bit_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output drivers; one enable per bit so the pad ring can split them
  always_comb begin
    oe_n_next = out_en_n_s ? NBCER_FLOAT_ALL[WIDTH-1:0]
                           : NBCER_ZERO_WORD[WIDTH-1:0];
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      oe_n_reg <= NBCER_FLOAT_ALL[WIDTH-1:0];
    end else begin
      oe_n_reg <= oe_n_next;
    end
  end

  // Non-inverted data straight from the stored flops
  assign BUS_OUT = stored_bit_reg;
  assign BUS_OUT_OE_N = oe_n_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  AST_LOAD_CAPTURE: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    clock_rise && !load_gate_n_s && zero_stored_n_s
    |=> stored_bit_reg == $past(data_s))
    else $error("stored word missed a gated load");

  AST_HOLD_GATED: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    load_gate_n_s && zero_stored_n_s |=> $stable(stored_bit_reg))
    else $error("stored word changed while the gate was off");

  AST_CLEAR_LOW: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    !zero_stored_n_s |=> stored_bit_reg == NBCER_ZERO_WORD[WIDTH-1:0])
    else $error("clear did not force the stored word low");

  AST_FLOAT_ALL: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    out_en_n_s |=> BUS_OUT_OE_N == NBCER_FLOAT_ALL[WIDTH-1:0])
    else $error("outputs not floated while disabled");

  AST_DRIVE_TRUE: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    !out_en_n_s ##1 !out_en_n_s
    |-> BUS_OUT_OE_N == NBCER_ZERO_WORD[WIDTH-1:0]
        && BUS_OUT == stored_bit_reg)
    else $error("outputs not driving the stored word");

  AST_NO_EDGE_NO_CHANGE: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    !clock_rise && zero_stored_n_s |=> stored_bit_reg == $past(BUS_OUT))
    else $error("stored word changed without a load edge");

  AST_OE_INDEPENDENT: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    $changed(out_en_n_s) && load_gate_n_s && zero_stored_n_s
    |=> $stable(stored_bit_reg))
    else $error("output enable disturbed the stored word");

  // Enabled outputs must start driving one cycle after the settled pin
  AST_DRIVE_ENABLE: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    !out_en_n_s |=> BUS_OUT_OE_N == NBCER_ZERO_WORD[WIDTH-1:0])
    else $error("outputs not enabled after the enable pin fell");

  // A split enable would leave some outputs driving while others float
  AST_OE_ALL_EQUAL: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    BUS_OUT_OE_N == NBCER_FLOAT_ALL[WIDTH-1:0]
    || BUS_OUT_OE_N == NBCER_ZERO_WORD[WIDTH-1:0])
    else $error("output enables disagree between bits");

  // Each settled enable change must reach the drivers a cycle later
  AST_OE_FOLLOWS_PIN: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    $changed(out_en_n_s) |=> $changed(BUS_OUT_OE_N))
    else $error("output enable change did not reach the drivers");

  // Clear wins even when a gated load edge lands in the same cycle
  AST_CLEAR_BEATS_LOAD: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    !zero_stored_n_s && clock_rise && !load_gate_n_s
    |=> stored_bit_reg == NBCER_ZERO_WORD[WIDTH-1:0])
    else $error("a load edge overrode the clear");

  // An edge that arrives with the gate off must be ignored
  AST_GATE_BLOCKS_EDGE: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    clock_rise && load_gate_n_s && zero_stored_n_s
    |=> $stable(stored_bit_reg))
    else $error("an ungated load edge changed the stored word");

  // A held-high load clock must not be seen as a second rise
  AST_RISE_SINGLE: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    clock_rise |=> !clock_rise)
    else $error("load clock rise detected twice in a row");

  // The word may change only through a clear or a gated load edge
  AST_CHANGE_NEEDS_CAUSE: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    $changed(stored_bit_reg)
    |-> !$past(zero_stored_n_s)
        || ($past(clock_rise) && !$past(load_gate_n_s)))
    else $error("stored word changed with no clear and no load");
endmodule

// file: dv/nbcer_bus_model.sv
// System logic that feeds the register: data word, load pins, controls
module nbcer_bus_model (
  input wire logic clk,
  output logic [nbcer_pkg::NBCER_WIDTH-1:0] data,
  output logic load_clock,
  output logic load_gate_n,
  output logic zero_n,
  output logic oe_n
);
  import nbcer_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////////////////
  // Idle pins: gate off, clear off, outputs floating
  initial begin
    data = '0;
    load_clock = 1'b0;
    load_gate_n = 1'b1;
    zero_n = 1'b1;
    oe_n = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////
  // One load clock rise, 2 cycles high and 2 low so the sampler sees it
  task automatic strobe(input logic [NBCER_WIDTH-1:0] d, input logic g);
    @(posedge clk);
    data <= d;
    load_gate_n <= g;
    @(posedge clk);
    load_clock <= 1'b1;
    repeat (2) @(posedge clk);
    load_clock <= 1'b0;
    data <= ~d; // Hold over: show the inverse, never the stale word
    repeat (2) @(posedge clk);
  endtask
  // Clear and output enable levels
  task automatic set_ctl(input logic z, input logic o);
    @(posedge clk);
    zero_n <= z;
    oe_n <= o;
  endtask
endmodule

// file: dv/testbench.sv
module testbench;
  import nbcer_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [NBCER_WIDTH-1:0] data_in;
  logic [NBCER_WIDTH-1:0] bus_out;
  logic [NBCER_WIDTH-1:0] bus_out_oe_n;
  logic load_clock;
  logic load_gate_n;
  logic zero_stored_n;
  logic out_en_n;
  int error_cnt = 0;
  int samples_checked = 0;
  // 125 MHz system clock
  always #4 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////////////
  nbcer_bus_model i_nbcer_bus_model (.clk(clk_sys), .data(data_in),
    .load_clock(load_clock), .load_gate_n(load_gate_n),
    .zero_n(zero_stored_n), .oe_n(out_en_n));
  nbcer_core i_nbcer_core (.CLK_SYS(clk_sys), .RST_N(rst_n),
    .DATA_IN(data_in), .LOAD_CLOCK(load_clock),
    .LOAD_GATE_N(load_gate_n), .ZERO_STORED_N(zero_stored_n),
    .OUT_EN_N(out_en_n), .BUS_OUT(bus_out), .BUS_OUT_OE_N(bus_out_oe_n));
  ////////////////////////////////////////////////////////////////////////
  task automatic compare(input string what, input logic [8:0] exp,
                         input logic [8:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Pins pass a 2-flop sampler; 4 edges covers the worst latency
  task automatic settle;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_load;
    i_nbcer_bus_model.set_ctl(1'b1, 1'b0);
    i_nbcer_bus_model.strobe(9'h1a5, 1'b0);
    settle;
    compare("bus_out", 9'h1a5, bus_out);
    compare("oe_n", 9'h000, bus_out_oe_n);
    // Every bit flips, so a stuck or swapped bit shows
    i_nbcer_bus_model.strobe(9'h05a, 1'b0);
    settle;
    compare("bus_out", 9'h05a, bus_out);
  endtask
  task automatic t_hold;
    i_nbcer_bus_model.strobe(9'h0f0, 1'b1);
    settle;
    compare("bus_out", 9'h05a, bus_out);
  endtask
  task automatic t_float;
    i_nbcer_bus_model.set_ctl(1'b1, 1'b1);
    settle;
    compare("oe_n", NBCER_FLOAT_ALL, bus_out_oe_n);
    i_nbcer_bus_model.strobe(9'h0c3, 1'b0);
    i_nbcer_bus_model.set_ctl(1'b1, 1'b0);
    settle;
    compare("bus_out", 9'h0c3, bus_out);
  endtask
  task automatic t_clear;
    i_nbcer_bus_model.set_ctl(1'b0, 1'b0);
    i_nbcer_bus_model.strobe(9'h1ff, 1'b0);
    settle;
    compare("bus_out", NBCER_ZERO_WORD, bus_out);
    i_nbcer_bus_model.set_ctl(1'b1, 1'b0);
    settle;
    compare("bus_out", NBCER_ZERO_WORD, bus_out);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Main sequence: reset for 8 cycles, then each scenario in turn
  initial begin
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    #1;
    compare("oe_n", NBCER_FLOAT_ALL, bus_out_oe_n);
    t_load;
    t_hold;
    t_float;
    t_clear;
    give_verdict;
  end
  // Watchdog: the scenarios need well under 200 cycles
  initial begin
    repeat (1000) @(posedge clk_sys);
    error_cnt++;
    $display("[ERR] watchdog expected done seen running");
    give_verdict;
  end
endmodule
